// ---- rdpc_pkg.sv ----
// Shared constants and types for the ROM and debug protection controller.
// Assumes both ends run on one 250 MHz clock.
package rdpc_pkg;
  localparam int ADDR_W = 8;
  localparam int CMD_W = 8;
  localparam int BLK_N = 4;
  localparam logic [7:0] OFS_ROM_CTRL = 8'h00;
  localparam logic [7:0] OFS_ROM_KEY = 8'h04;
  localparam logic [7:0] OFS_DBG_MODE = 8'h08;
  localparam logic [7:0] OFS_DBG_KEY = 8'h0c;
  localparam logic [7:0] OFS_FLASH_CMD = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_HOST_CTRL = 8'h80;
  localparam logic [7:0] OFS_HOST_SEQ = 8'h84;
  localparam int HOST_SPACE_BIT = 7;
  localparam logic [31:0] ROM_KEY_CODE = 32'h0000_003d;
  localparam logic [31:0] DBG_KEY_CODE = 32'h0000_00c5;
  localparam int GUARD_ON_BIT = 0;
  localparam logic GUARD_ON_RST = 1'b1;
  localparam logic [7:0] CMD_PROT_ERASE = 8'h01;
  localparam logic [7:0] CMD_PROT_PROG = 8'h02;
  localparam int ST_FLASH_PROT = 0;
  localparam int ST_ROM_PROT = 1;
  localparam int ST_DBG_PROT = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_BLK_LSB = 4;
  localparam int ST_MASK_TYPE = 8;
  localparam int HC_FROM_ROM = 0;
  localparam int HC_PROBE = 1;
  localparam int HS_VAL_BIT = 2;
  typedef enum logic [2:0] {
    RDPC_IDLE = 3'b001,
    RDPC_ERASE = 3'b010,
    RDPC_CLEAR = 3'b100
  } rdpc_state_t;
  typedef enum logic [1:0] {
    RDPC_K_ROM = 2'h0,
    RDPC_K_DBG = 2'h1,
    RDPC_K_REL = 2'h2,
    RDPC_K_PROG = 2'h3
  } rdpc_kind_t;
endpackage

// ---- rdpc_if.sv ----
// Register link between the processor-side end and the protection controller.
// Assumes both ends share REF_CLK_IN; the device answers reads combinationally.
`timescale 1ns/100ps
interface rdpc_if;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic word;
  logic from_rom;
  logic probe_en;
  logic [31:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, input word,
    input from_rom, input probe_en, output rdata);
  modport cpu (output addr, output wdata, output wr, output rd, output word,
    output from_rom, output probe_en, input rdata);
endinterface

// ---- rdpc_dev.sv ----
// Protection controller: ROM guard, debug guard and the protect-release sequence.
// Assumes the flash macro and processor core sit on REF_CLK_IN.
`timescale 1ns/100ps
module rdpc_dev
  import rdpc_pkg::*;
#(
  parameter bit IS_MASK = 1'b0
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic POR_N_IN,
  input wire logic [BLK_N-1:0] BLK_PROT_IN,
  input wire logic ERASE_DONE_IN,
  rdpc_if.dev LINK,
  output logic DEBUG_SUPPORT_UNIT_EN_OUT,
  output logic DEBUG_PROBE_ENABLE_OUT,
  output logic ROM_PROT_OUT,
  output logic FLASH_CMD_VALID_OUT,
  output logic [CMD_W-1:0] FLASH_CMD_OUT,
  output logic FLASH_ERASE_OUT,
  output logic PROT_CLEAR_OUT
);
  logic guard_rst_n;
  logic flash_prot;
  logic rom_prot;
  logic dbg_prot;
  logic wr_ok;
  logic rom_on;
  logic rom_pend;
  logic dbg_on;
  logic dbg_pend;
  logic next_rom_on;
  logic next_rom_pend;
  logic next_dbg_on;
  logic next_dbg_pend;
  rdpc_state_t state;
  rdpc_state_t next_state;
  logic cmd_valid;
  logic [CMD_W-1:0] cmd_code;
  logic next_cmd_valid;
  logic [CMD_W-1:0] next_cmd_code;
  logic unit_en;
  logic probe;
  logic rom_prot_q;
  logic next_unit_en;
  logic next_probe;
  logic next_rom_prot_q;
  logic [31:0] status;

  // The guards survive warm resets in the flash part; the mask part has no power-on circuit.
  assign guard_rst_n = IS_MASK ? RST_N_IN : POR_N_IN;
  assign flash_prot = IS_MASK ? 1'b1 : &BLK_PROT_IN;
  assign rom_prot = flash_prot & rom_on;
  assign dbg_prot = flash_prot & dbg_on;
  assign wr_ok = LINK.wr & LINK.word & (~rom_prot | LINK.from_rom);

  always_comb begin
    status = 32'h0000_0000;
    status[ST_FLASH_PROT] = flash_prot;
    status[ST_ROM_PROT] = rom_prot;
    status[ST_DBG_PROT] = dbg_prot;
    status[ST_BUSY] = (state != RDPC_IDLE);
    status[ST_BLK_LSB +: BLK_N] = BLK_PROT_IN;
    status[ST_MASK_TYPE] = IS_MASK;
  end

  // Key registers have no storage, so a read of them shows zero whatever was written.
  always_comb begin
    LINK.rdata = 32'h0000_0000;
    if (LINK.rd && LINK.word) begin
      unique case (LINK.addr)
        OFS_ROM_CTRL: begin
          LINK.rdata[GUARD_ON_BIT] = rom_on;
        end
        OFS_DBG_MODE: begin
          LINK.rdata[GUARD_ON_BIT] = dbg_on;
        end
        OFS_STATUS: begin
          LINK.rdata = status;
        end
        default: begin
          LINK.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Guard group: a written value waits in the pending bit until the key arrives.
  always_comb begin
    next_rom_on = rom_on;
    next_rom_pend = rom_pend;
    next_dbg_on = dbg_on;
    next_dbg_pend = dbg_pend;
    if (wr_ok) begin
      unique case (LINK.addr)
        OFS_ROM_CTRL: begin
          next_rom_pend = LINK.wdata[GUARD_ON_BIT];
        end
        OFS_ROM_KEY: begin
          if (LINK.wdata == ROM_KEY_CODE) begin
            next_rom_on = rom_pend;
          end
        end
        OFS_DBG_MODE: begin
          next_dbg_pend = LINK.wdata[GUARD_ON_BIT];
        end
        OFS_DBG_KEY: begin
          if (LINK.wdata == DBG_KEY_CODE) begin
            next_dbg_on = dbg_pend;
          end
        end
        default: begin
          next_rom_on = rom_on;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge guard_rst_n) begin
    if (!guard_rst_n) begin
      rom_on <= GUARD_ON_RST;
      rom_pend <= GUARD_ON_RST;
      dbg_on <= GUARD_ON_RST;
      dbg_pend <= GUARD_ON_RST;
    end else begin
      rom_on <= next_rom_on;
      rom_pend <= next_rom_pend;
      dbg_on <= next_dbg_on;
      dbg_pend <= next_dbg_pend;
    end
  end

  // Command group: forwards flash commands and, in the flash part only, runs the erase-then-clear release.
  always_comb begin
    next_state = state;
    next_cmd_valid = 1'b0;
    next_cmd_code = cmd_code;
    unique case (state)
      RDPC_IDLE: begin
        if (wr_ok && LINK.addr == OFS_FLASH_CMD && !rom_prot) begin
          if (IS_MASK && (LINK.wdata[CMD_W-1:0] == CMD_PROT_ERASE
              || LINK.wdata[CMD_W-1:0] == CMD_PROT_PROG)) begin
            next_cmd_valid = 1'b0;
          end else if (LINK.wdata[CMD_W-1:0] == CMD_PROT_ERASE && flash_prot) begin
            next_state = RDPC_ERASE;
          end else begin
            next_cmd_valid = 1'b1;
            next_cmd_code = LINK.wdata[CMD_W-1:0];
          end
        end
      end
      RDPC_ERASE: begin
        if (ERASE_DONE_IN) begin
          next_state = RDPC_CLEAR;
        end
      end
      RDPC_CLEAR: begin
        if (BLK_PROT_IN == '0) begin
          next_state = RDPC_IDLE;
        end
      end
      default: begin
        next_state = RDPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state <= RDPC_IDLE;
      cmd_valid <= 1'b0;
      cmd_code <= '0;
    end else begin
      state <= next_state;
      cmd_valid <= next_cmd_valid;
      cmd_code <= next_cmd_code;
    end
  end

  // Output group: the ROM protect state, debug unit enable and probe enable are registered once before they leave.
  always_comb begin
    next_unit_en = ~dbg_prot;
    next_probe = LINK.probe_en;
    next_rom_prot_q = rom_prot;
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      unit_en <= 1'b0;
      probe <= 1'b0;
      rom_prot_q <= 1'b1;
    end else begin
      unit_en <= next_unit_en;
      probe <= next_probe;
      rom_prot_q <= next_rom_prot_q;
    end
  end

  assign DEBUG_SUPPORT_UNIT_EN_OUT = unit_en;
  assign DEBUG_PROBE_ENABLE_OUT = probe;
  assign ROM_PROT_OUT = rom_prot_q;
  assign FLASH_CMD_VALID_OUT = cmd_valid;
  assign FLASH_CMD_OUT = cmd_code;
  assign FLASH_ERASE_OUT = state[1];
  assign PROT_CLEAR_OUT = state[2];
endmodule

// ---- rdpc_cpu.sv ----
// Processor-side end: forwards software accesses and runs guard sequences.
// Assumes the device answers a read in the same cycle on the link.
`timescale 1ns/100ps
module rdpc_cpu
  import rdpc_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [ADDR_W-1:0] SW_ADDR_IN,
  input wire logic [31:0] SW_WDATA_IN,
  input wire logic SW_WR_IN,
  input wire logic SW_RD_IN,
  output logic [31:0] SW_RDATA_OUT,
  rdpc_if.cpu LINK
);
  logic from_rom;
  logic probe;
  logic busy;
  rdpc_kind_t kind;
  logic val;
  logic [1:0] step;
  logic [31:0] rdata;
  logic next_from_rom;
  logic next_probe;
  logic next_busy;
  rdpc_kind_t next_kind;
  logic next_val;
  logic [1:0] next_step;
  logic [31:0] next_rdata;
  logic local_sel;
  logic [7:0] seq_addr;
  logic [31:0] seq_data;
  logic seq_last;

  assign local_sel = SW_ADDR_IN[HOST_SPACE_BIT];

  // Step table of the sequencer; it behaves like a release program kept in ROM.
  always_comb begin
    seq_addr = OFS_FLASH_CMD;
    seq_data = 32'h0000_0000;
    seq_last = 1'b0;
    unique case (kind)
      RDPC_K_ROM, RDPC_K_DBG: begin
        seq_addr = (kind == RDPC_K_ROM) ? OFS_ROM_CTRL : OFS_DBG_MODE;
        seq_data[GUARD_ON_BIT] = val;
        if (step != 2'h0) begin
          seq_addr = (kind == RDPC_K_ROM) ? OFS_ROM_KEY : OFS_DBG_KEY;
          seq_data = (kind == RDPC_K_ROM) ? ROM_KEY_CODE : DBG_KEY_CODE;
          seq_last = 1'b1;
        end
      end
      RDPC_K_REL: begin
        seq_addr = (step == 2'h0) ? OFS_ROM_CTRL : OFS_ROM_KEY;
        seq_data = (step == 2'h0) ? 32'h0000_0000 : ROM_KEY_CODE;
        if (step == 2'h2) begin
          seq_addr = OFS_FLASH_CMD;
          seq_data = {24'h00_0000, CMD_PROT_ERASE};
          seq_last = 1'b1;
        end
      end
      RDPC_K_PROG: begin
        seq_data = {24'h00_0000, CMD_PROT_PROG};
        seq_last = 1'b1;
      end
    endcase
  end

  always_comb begin
    LINK.word = 1'b1;
    LINK.probe_en = probe;
    LINK.from_rom = busy | from_rom;
    LINK.addr = busy ? seq_addr : SW_ADDR_IN;
    LINK.wdata = busy ? seq_data : SW_WDATA_IN;
    LINK.wr = busy | (SW_WR_IN & ~local_sel);
    LINK.rd = ~busy & SW_RD_IN & ~local_sel;
  end

  always_comb begin
    next_from_rom = from_rom;
    next_probe = probe;
    next_busy = busy;
    next_kind = kind;
    next_val = val;
    next_step = step;
    next_rdata = 32'h0000_0000;
    if (busy) begin
      next_step = step + 2'h1;
      if (seq_last) begin
        next_busy = 1'b0;
        next_step = 2'h0;
      end
    end
    if (SW_WR_IN && SW_ADDR_IN == OFS_HOST_CTRL) begin
      next_from_rom = SW_WDATA_IN[HC_FROM_ROM];
      next_probe = SW_WDATA_IN[HC_PROBE];
    end
    if (SW_WR_IN && SW_ADDR_IN == OFS_HOST_SEQ && !busy) begin
      next_busy = 1'b1;
      next_kind = rdpc_kind_t'(SW_WDATA_IN[1:0]);
      next_val = SW_WDATA_IN[HS_VAL_BIT];
      next_step = 2'h0;
      if (SW_WDATA_IN[1:0] == RDPC_K_PROG) begin
        next_probe = 1'b1;
      end
    end
    if (SW_RD_IN) begin
      if (SW_ADDR_IN == OFS_HOST_CTRL) begin
        next_rdata[HC_FROM_ROM] = from_rom;
        next_rdata[HC_PROBE] = probe;
      end else if (SW_ADDR_IN == OFS_HOST_SEQ) begin
        next_rdata[0] = busy;
      end else if (!local_sel && !busy) begin
        next_rdata = LINK.rdata;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      from_rom <= 1'b0;
      probe <= 1'b0;
      busy <= 1'b0;
      kind <= RDPC_K_ROM;
      val <= 1'b0;
      step <= 2'h0;
      rdata <= 32'h0000_0000;
    end else begin
      from_rom <= next_from_rom;
      probe <= next_probe;
      busy <= next_busy;
      kind <= next_kind;
      val <= next_val;
      step <= next_step;
      rdata <= next_rdata;
    end
  end

  assign SW_RDATA_OUT = rdata;
endmodule

// ---- rdpc_monitor.sv ----
// Checker for the link between both ends and for the device outputs.
// Assumes one clock domain; placed beside the link interface in the bench.
`timescale 1ns/100ps
module rdpc_monitor
  import rdpc_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic probe_en,
  input wire logic [31:0] rdata,
  input wire logic [BLK_N-1:0] BLK_PROT_IN,
  input wire logic ERASE_DONE_IN,
  input wire logic DEBUG_SUPPORT_UNIT_EN_OUT,
  input wire logic DEBUG_PROBE_ENABLE_OUT,
  input wire logic ROM_PROT_OUT,
  input wire logic FLASH_CMD_VALID_OUT,
  input wire logic FLASH_ERASE_OUT,
  input wire logic PROT_CLEAR_OUT
);
  logic erase_wr;
  assign erase_wr = wr && addr == OFS_FLASH_CMD && wdata[7:0] == CMD_PROT_ERASE;
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_cmd_wr;
    wr && addr == OFS_FLASH_CMD;
  endsequence
  sequence s_erase_done;
    FLASH_ERASE_OUT && ERASE_DONE_IN;
  endsequence
  // The output lags the guard by one cycle, so the cycle after the write shows its state.
  property p_rom_cmd;
    s_cmd_wr ##1 ROM_PROT_OUT |-> !FLASH_CMD_VALID_OUT;
  endproperty
  a_rom_cmd: assert property (p_rom_cmd) else $error("flash command passed while protected");
  property p_open_rom;
    !(&BLK_PROT_IN) |=> !ROM_PROT_OUT;
  endproperty
  a_open_rom: assert property (p_open_rom) else $error("ROM protected without all blocks");
  property p_open_unit;
    !(&BLK_PROT_IN) |=> DEBUG_SUPPORT_UNIT_EN_OUT;
  endproperty
  a_open_unit: assert property (p_open_unit) else $error("debug unit locked while flash open");
  property p_erase_to_clear;
    s_erase_done |=> !FLASH_ERASE_OUT && PROT_CLEAR_OUT;
  endproperty
  a_erase_to_clear: assert property (p_erase_to_clear) else $error("clear did not follow erase");
  property p_clear_after;
    $rose(PROT_CLEAR_OUT) |-> $past(FLASH_ERASE_OUT);
  endproperty
  a_clear_after: assert property (p_clear_after) else $error("clear began without erase");
  property p_erase_start;
    $rose(FLASH_ERASE_OUT) |-> $past(erase_wr);
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("erase began without command");
  property p_excl;
    !(FLASH_ERASE_OUT && PROT_CLEAR_OUT);
  endproperty
  a_excl: assert property (p_excl) else $error("erase and clear overlap");
  property p_clear_end;
    PROT_CLEAR_OUT && BLK_PROT_IN == 4'h0 |=> !PROT_CLEAR_OUT;
  endproperty
  a_clear_end: assert property (p_clear_end) else $error("clear phase did not end");
  property p_key_rd;
    rd && (addr == OFS_ROM_KEY || addr == OFS_DBG_KEY) |-> rdata == 32'h0;
  endproperty
  a_key_rd: assert property (p_key_rd) else $error("key register read back data");
  property p_probe;
    1'b1 |=> DEBUG_PROBE_ENABLE_OUT == $past(probe_en);
  endproperty
  a_probe: assert property (p_probe) else $error("probe output not following link");
endmodule

// ---- rom_and_debug_protect_ctrl_tb_top.sv ----
// Bench for both ends joined by the link, driven through the software port.
// Assumes the flash variant on the processor path; a mask-variant device is driven directly.
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module rom_and_debug_protect_ctrl_tb_top
  import rdpc_pkg::*;
;
  logic clk = 0, rst_n = 0, por_n = 0, done = 0, wr = 0, rd = 0, seen = 0;
  logic [3:0] blk = 4'hf;
  logic [7:0] a = 8'h00, cmd;
  logic [31:0] d = 32'h0, q, v;
  logic unit_en, probe, rp, cv, er, cl;
  logic m_wr = 0, m_rd = 0, m_seen = 0, m_unit_en, m_rp, m_cv, m_er;
  logic [7:0] m_cmd;
  int fails = 0, total_checks = 0, cyc = 0;
  rdpc_if u_rdpc_if();
  rdpc_if u_rdpc_if_mask();
  rdpc_dev #(.IS_MASK(1'b0)) u_rdpc_dev(.REF_CLK_IN(clk), .RST_N_IN(rst_n), .POR_N_IN(por_n),
    .BLK_PROT_IN(blk), .ERASE_DONE_IN(done), .LINK(u_rdpc_if.dev),
    .DEBUG_SUPPORT_UNIT_EN_OUT(unit_en), .DEBUG_PROBE_ENABLE_OUT(probe), .ROM_PROT_OUT(rp),
    .FLASH_CMD_VALID_OUT(cv), .FLASH_CMD_OUT(cmd), .FLASH_ERASE_OUT(er), .PROT_CLEAR_OUT(cl));
  rdpc_dev #(.IS_MASK(1'b1)) u_rdpc_dev_mask(.REF_CLK_IN(clk), .RST_N_IN(rst_n),
    .POR_N_IN(por_n), .BLK_PROT_IN(blk), .ERASE_DONE_IN(done), .LINK(u_rdpc_if_mask.dev),
    .DEBUG_SUPPORT_UNIT_EN_OUT(m_unit_en), .DEBUG_PROBE_ENABLE_OUT(), .ROM_PROT_OUT(m_rp),
    .FLASH_CMD_VALID_OUT(m_cv), .FLASH_CMD_OUT(m_cmd), .FLASH_ERASE_OUT(m_er),
    .PROT_CLEAR_OUT());
  assign u_rdpc_if_mask.addr = a;
  assign u_rdpc_if_mask.wdata = d;
  assign u_rdpc_if_mask.wr = m_wr;
  assign u_rdpc_if_mask.rd = m_rd;
  assign u_rdpc_if_mask.word = 1'b1;
  // The mask link stands for a release program kept in ROM, so every access is a ROM fetch.
  assign u_rdpc_if_mask.from_rom = 1'b1;
  assign u_rdpc_if_mask.probe_en = 1'b0;
  rdpc_cpu u_rdpc_cpu(.REF_CLK_IN(clk), .RST_N_IN(rst_n), .SW_ADDR_IN(a), .SW_WDATA_IN(d),
    .SW_WR_IN(wr), .SW_RD_IN(rd), .SW_RDATA_OUT(q), .LINK(u_rdpc_if.cpu));
  rdpc_monitor u_rdpc_monitor(.REF_CLK_IN(clk), .RST_N_IN(rst_n), .addr(u_rdpc_if.addr),
    .wdata(u_rdpc_if.wdata), .wr(u_rdpc_if.wr), .rd(u_rdpc_if.rd),
    .probe_en(u_rdpc_if.probe_en), .rdata(u_rdpc_if.rdata), .BLK_PROT_IN(blk),
    .ERASE_DONE_IN(done), .DEBUG_SUPPORT_UNIT_EN_OUT(unit_en), .DEBUG_PROBE_ENABLE_OUT(probe),
    .ROM_PROT_OUT(rp), .FLASH_CMD_VALID_OUT(cv), .FLASH_ERASE_OUT(er), .PROT_CLEAR_OUT(cl));
  always #2 clk = ~clk;
  // The command pulse lasts one cycle, so it is latched here rather than polled.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cv) seen <= 1'b1;
    if (m_cv) m_seen <= 1'b1;
    if (cyc == 4000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic sw_w(input logic [7:0] ad, input logic [31:0] da);
    @(posedge clk);
    a <= ad;
    d <= da;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic sw_r(input logic [7:0] ad);
    @(posedge clk);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = q;
  endtask
  task automatic m_w(input logic [7:0] ad, input logic [31:0] da);
    @(posedge clk);
    a <= ad;
    d <= da;
    m_wr <= 1'b1;
    @(posedge clk);
    m_wr <= 1'b0;
  endtask
  task automatic m_r(input logic [7:0] ad);
    @(posedge clk);
    a <= ad;
    m_rd <= 1'b1;
    #1 v = u_rdpc_if_mask.rdata;
    @(posedge clk);
    m_rd <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] ad, input logic [31:0] e);
    sw_r(ad);
    `CHK("rd", e, v)
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 30; i++) begin
      sw_r(OFS_HOST_SEQ);
      if (v[0] === 1'b0) break;
    end
    `CHK("idle", 1'b0, v[0])
  endtask
  task automatic pulse_rst(input logic both);
    @(posedge clk);
    rst_n <= 1'b0;
    if (both) por_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    chk(OFS_STATUS, 32'h0f7);
    chk(OFS_ROM_CTRL, 32'h1);
    chk(OFS_DBG_MODE, 32'h1);
    `CHK("unit", 1'b0, unit_en)
    sw_w(OFS_ROM_CTRL, 32'h0);
    sw_w(OFS_ROM_KEY, ROM_KEY_CODE);
    chk(OFS_ROM_CTRL, 32'h1);
    sw_w(OFS_HOST_CTRL, 32'h1);
    sw_w(OFS_ROM_CTRL, 32'h0);
    sw_w(OFS_ROM_KEY, 32'h3c);
    chk(OFS_ROM_CTRL, 32'h1);
    sw_w(OFS_ROM_KEY, ROM_KEY_CODE);
    chk(OFS_STATUS, 32'h0f5);
    `CHK("rp", 1'b0, rp)
    chk(OFS_ROM_KEY, 32'h0);
    sw_w(OFS_DBG_MODE, 32'h0);
    sw_w(OFS_DBG_KEY, DBG_KEY_CODE);
    chk(OFS_DBG_KEY, 32'h0);
    chk(OFS_STATUS, 32'h0f1);
    `CHK("unit", 1'b1, unit_en)
    pulse_rst(1'b0);
    chk(OFS_ROM_CTRL, 32'h0);
    chk(OFS_DBG_MODE, 32'h0);
    sw_w(OFS_FLASH_CMD, {24'h0, CMD_PROT_PROG});
    @(posedge clk);
    #1 `CHK("cmd", CMD_PROT_PROG, cmd)
    `CHK("seen", 1'b1, seen)
    pulse_rst(1'b1);
    seen <= 1'b0;
    chk(OFS_STATUS, 32'h0f7);
    sw_w(OFS_DBG_MODE, 32'h0);
    sw_w(OFS_DBG_KEY, DBG_KEY_CODE);
    chk(OFS_DBG_MODE, 32'h1);
    sw_w(OFS_HOST_CTRL, 32'h1);
    sw_w(OFS_FLASH_CMD, {24'h0, CMD_PROT_PROG});
    @(posedge clk);
    #1 `CHK("seen", 1'b0, seen)
    @(posedge clk);
    blk <= 4'h7;
    chk(OFS_STATUS, 32'h070);
    `CHK("unit", 1'b1, unit_en)
    @(posedge clk);
    blk <= 4'hf;
    sw_w(OFS_HOST_SEQ, 32'h2);
    for (int i = 0; i < 40 && er !== 1'b1; i++) @(posedge clk);
    `CHK("er", 1'b1, er)
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    #1 `CHK("cl", 1'b1, cl)
    `CHK("er", 1'b0, er)
    @(posedge clk);
    blk <= 4'h0;
    repeat (2) @(posedge clk);
    #1 `CHK("cl", 1'b0, cl)
    wait_idle();
    chk(OFS_STATUS, 32'h000);
    chk(OFS_ROM_CTRL, 32'h0);
    seen <= 1'b0;
    sw_w(OFS_HOST_SEQ, 32'h3);
    wait_idle();
    `CHK("seen", 1'b1, seen)
    `CHK("probe", 1'b1, probe)
    m_r(OFS_STATUS);
    `CHK("mask status", 32'h107, v)
    `CHK("mask rp", 1'b1, m_rp)
    `CHK("mask unit", 1'b0, m_unit_en)
    m_w(OFS_ROM_CTRL, 32'h0);
    m_w(OFS_ROM_KEY, ROM_KEY_CODE);
    m_w(OFS_FLASH_CMD, {24'h0, CMD_PROT_ERASE});
    m_w(OFS_FLASH_CMD, {24'h0, CMD_PROT_PROG});
    @(posedge clk);
    #1 `CHK("mask seen", 1'b0, m_seen)
    `CHK("mask er", 1'b0, m_er)
    m_r(OFS_STATUS);
    `CHK("mask status", 32'h105, v)
    m_w(OFS_FLASH_CMD, 32'h5);
    @(posedge clk);
    #1 `CHK("mask seen", 1'b1, m_seen)
    `CHK("mask cmd", 8'h05, m_cmd)
    pulse_rst(1'b0);
    m_r(OFS_ROM_CTRL);
    `CHK("mask guard", 32'h1, v)
    report_and_stop();
  end
endmodule
